// ===== logic/acs_defs.svh
// constants for the converter control block: timing counts and result framing
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH

// ----------------------------------------------------------------
// clock and timing figures
// ----------------------------------------------------------------
`define ACS_CLK_NS        10
`define ACS_CONV_MAX_NS   3700
`define ACS_ACQ_MIN_NS    1400
`define ACS_WAKE_NS       1000
`define ACS_CSW_NS        30
// longest time rounds down: cycles from falling edge to msb on the output
`define ACS_CONV_CYC      (`ACS_CONV_MAX_NS / `ACS_CLK_NS)
// cycles per approximation step, leaving room for the pin and comparator syncs
`define ACS_BIT_CYC       ((`ACS_CONV_CYC - `ACS_RES_BITS) / `ACS_RES_BITS)

// ----------------------------------------------------------------
// result framing
// ----------------------------------------------------------------
`define ACS_RES_BITS      10
`define ACS_FRAME_BITS    12
`define ACS_SAR_RST       10'h000
`define ACS_SAR_FIRST     10'h200
`define ACS_CNT_W         8

`endif

// ===== logic/acs_pkg.sv
// types shared by the converter control block
package acs_pkg;
  // control states, one-hot
  typedef enum logic [2:0] {
    ACS_SHUT  = 3'b001,
    ACS_TRACK = 3'b010,
    ACS_CONV  = 3'b100
  } acs_state_t;
endpackage

// ===== logic/acs_ctrl.sv
// converter control: track, hold, approximation, shutdown and serial readout
`timescale 1ns/1ns
// Notes on behaviour
// - convert-start rise puts sampler into tracking
// - convert-start fall holds sample, starts conversion
// - msb on output within 3.7 us
// - shutdown automatically after each conversion
// - track connects positive and negative capacitors
// - single rise from shutdown after reset or a full twelve-rise readout picks channel one
// - short readout at rise picks channel two
// - after the msb, output changes only on serial clock falls until the next convert-start rise
// - ten result bits leave msb first
// - rise wakes device and drives output low
// - after twelve bits output goes high-impedance
`include "acs_defs.svh"

module acs_ctrl (
  input  wire logic                      ref_clk,          // system clock, 100 MHz
  input  wire logic                      rst,              // synchronous reset, active high
  input  wire logic                      link_sclk,        // serial clock from the host
  input  wire logic                      convert_start_pin, // convert-start pin, asynchronous
  input  wire logic                      comparator_high,  // analog comparator: input >= trial
  output logic                           sample_track,     // sampler tracking
  output logic                           sample_hold,      // sampler holding
  output logic                           pos_cap_first,    // positive cap on first channel
  output logic                           pos_cap_second,   // positive cap on second channel
  output logic                           neg_cap_connect,  // negative cap to ground / negative input
  output logic                           power_up,         // analog core powered
  output logic [`ACS_RES_BITS-1:0]       dac_trial,        // trial code for the capacitor dac
  output logic                           serial_data_out,  // serial data pin level
  output logic                           serial_data_oe    // serial data pin driven
);

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  function automatic logic [`ACS_CNT_W-1:0] bin2gray(input logic [`ACS_CNT_W-1:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [`ACS_CNT_W-1:0] gray2bin(input logic [`ACS_CNT_W-1:0] g);
    logic [`ACS_CNT_W-1:0] b;
    b = g;
    for (int i = `ACS_CNT_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // bit of the frame for a given count of clock falls; trailing bits are zero
  function automatic logic frame_bit(input logic [`ACS_RES_BITS-1:0] r, input logic [`ACS_CNT_W-1:0] idx);
    logic [`ACS_CNT_W-1:0] k;
    k = 8'h09 - idx;
    return (idx < 8'h0A) ? r[k[3:0]] : 1'b0;
  endfunction

  // ----------------------------------------------------------------
  // link domain: free-running gray counters of serial clock edges
  // ----------------------------------------------------------------
  logic                   lrst_s1_q;   // reset into link domain, first stage
  logic                   lrst_s2_q;   // reset into link domain, second stage
  logic [`ACS_CNT_W-1:0]  rise_cnt_q;  // rising edges, binary
  logic [`ACS_CNT_W-1:0]  rise_gry_q;  // rising edges, gray for the crossing
  logic [`ACS_CNT_W-1:0]  fall_cnt_q;  // falling edges, binary
  logic [`ACS_CNT_W-1:0]  fall_gry_q;  // falling edges, gray for the crossing

  // reset synchroniser; the link clock must run during reset
  always_ff @(posedge link_sclk) begin
    lrst_s1_q <= rst;
    lrst_s2_q <= lrst_s1_q;
  end

  // only counts cross, never data: the result stays in the system domain
  always_ff @(posedge link_sclk) begin
    if (lrst_s2_q) begin
      rise_cnt_q <= 8'h00;
      rise_gry_q <= 8'h00;
    end else begin
      rise_cnt_q <= rise_cnt_q + 8'h01;
      rise_gry_q <= bin2gray(rise_cnt_q + 8'h01);
    end
  end

  // falls step the bit pointer, so the host may sample on rises
  always_ff @(negedge link_sclk) begin
    if (lrst_s2_q) begin
      fall_cnt_q <= 8'h00;
      fall_gry_q <= 8'h00;
    end else begin
      fall_cnt_q <= fall_cnt_q + 8'h01;
      fall_gry_q <= bin2gray(fall_cnt_q + 8'h01);
    end
  end

  // ----------------------------------------------------------------
  // system domain: synchronisers
  // ----------------------------------------------------------------
  logic                   cs_s1_q, cs_s2_q, cs_s3_q;   // convert-start pin stages
  logic                   cmp_s1_q, cmp_s2_q;          // comparator stages
  logic [`ACS_CNT_W-1:0]  rg_s1_q, rg_s2_q;            // rise count stages
  logic [`ACS_CNT_W-1:0]  fg_s1_q, fg_s2_q;            // fall count stages
  logic                   cs_rise;                     // pin edge seen rising
  logic                   cs_fall;                     // pin edge seen falling

  // a 30 ns pulse spans three clocks, so no edge of the pattern is missed
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cs_s1_q  <= 1'b0;
      cs_s2_q  <= 1'b0;
      cs_s3_q  <= 1'b0;
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
      rg_s1_q  <= 8'h00;
      rg_s2_q  <= 8'h00;
      fg_s1_q  <= 8'h00;
      fg_s2_q  <= 8'h00;
    end else begin
      cs_s1_q  <= convert_start_pin;
      cs_s2_q  <= cs_s1_q;
      cs_s3_q  <= cs_s2_q;
      cmp_s1_q <= comparator_high;
      cmp_s2_q <= cmp_s1_q;
      rg_s1_q  <= rise_gry_q;
      rg_s2_q  <= rg_s1_q;
      fg_s1_q  <= fall_gry_q;
      fg_s2_q  <= fg_s1_q;
    end
  end

  assign cs_rise = cs_s2_q & ~cs_s3_q;
  assign cs_fall = ~cs_s2_q & cs_s3_q;

  // ----------------------------------------------------------------
  // edge counts since the last completed conversion
  // ----------------------------------------------------------------
  logic [`ACS_CNT_W-1:0]  rise_base_q;  // rise count at completion
  logic [`ACS_CNT_W-1:0]  fall_base_q;  // fall count at completion
  logic [`ACS_CNT_W-1:0]  rise_since;   // rises after completion
  logic [`ACS_CNT_W-1:0]  fall_since;   // falls after completion
  logic                   conv_done;    // last approximation step ends
  logic                   valid_q;      // a result waits to be read
  logic                   full_q;       // twelve rises were seen for the last result
  logic                   released_q;   // output released after the frame
  logic                   read_full;    // twelve rises seen right now

  assign rise_since = gray2bin(rg_s2_q) - rise_base_q;
  assign fall_since = gray2bin(fg_s2_q) - fall_base_q;
  assign read_full  = valid_q && (rise_since >= 8'h0C);

  // snapshot both counts when the result appears
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rise_base_q <= 8'h00;
      fall_base_q <= 8'h00;
    end else if (conv_done) begin
      rise_base_q <= gray2bin(rg_s2_q);
      fall_base_q <= gray2bin(fg_s2_q);
    end
  end

  // readout bookkeeping; reset counts as a finished readout
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      valid_q    <= 1'b0;
      full_q     <= 1'b1;
      released_q <= 1'b0;
    end else if (cs_rise) begin
      valid_q    <= 1'b0;
      full_q     <= 1'b0;
      released_q <= 1'b0;
    end else begin
      if (conv_done) begin
        valid_q <= 1'b1;
      end
      if (read_full) begin
        full_q     <= 1'b1;
        released_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // control state machine and channel choice
  // ----------------------------------------------------------------
  acs_pkg::acs_state_t    st_q;        // control state
  logic                   chan_two_q;  // second channel chosen
  logic [3:0]             bit_q;       // bit under trial
  logic [5:0]             step_q;      // cycles within a step
  logic [`ACS_RES_BITS-1:0] sar_q;     // approximation register
  logic [`ACS_RES_BITS-1:0] result_q;  // finished result
  logic [`ACS_RES_BITS-1:0] sar_keep;  // trial bit judged by the comparator

  assign conv_done = (st_q == acs_pkg::ACS_CONV) && (step_q == 6'(`ACS_BIT_CYC - 1)) && (bit_q == 4'h0);
  assign sar_keep  = cmp_s2_q ? sar_q : (sar_q & ~(10'h001 << bit_q));

  // a rise always restarts tracking, even mid-conversion
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q       <= acs_pkg::ACS_SHUT;
      chan_two_q <= 1'b0;
    end else if (cs_rise) begin
      st_q       <= acs_pkg::ACS_TRACK;
      chan_two_q <= ~(full_q | read_full);
    end else begin
      case (st_q)
        acs_pkg::ACS_SHUT: begin
          st_q <= acs_pkg::ACS_SHUT;
        end
        acs_pkg::ACS_TRACK: begin
          if (cs_fall) begin
            st_q <= acs_pkg::ACS_CONV;
          end
        end
        acs_pkg::ACS_CONV: begin
          if (conv_done) begin
            st_q <= acs_pkg::ACS_SHUT;
          end
        end
        default: begin
          st_q <= acs_pkg::ACS_SHUT;
        end
      endcase
    end
  end

  // approximation: one bit per step, msb first
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bit_q    <= 4'h9;
      step_q   <= 6'h00;
      sar_q    <= `ACS_SAR_RST;
      result_q <= `ACS_SAR_RST;
    end else if (st_q != acs_pkg::ACS_CONV || cs_rise) begin
      bit_q  <= 4'h9;
      step_q <= 6'h00;
      sar_q  <= `ACS_SAR_FIRST;
    end else if (step_q == 6'(`ACS_BIT_CYC - 1)) begin
      step_q <= 6'h00;
      if (bit_q == 4'h0) begin
        result_q <= sar_keep;
        sar_q    <= sar_keep;
      end else begin
        bit_q <= bit_q - 4'h1;
        sar_q <= sar_keep | (10'h001 << (bit_q - 4'h1));
      end
    end else begin
      step_q <= step_q + 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // analog switch controls
  // ----------------------------------------------------------------
  assign sample_track    = (st_q == acs_pkg::ACS_TRACK);
  assign sample_hold     = (st_q == acs_pkg::ACS_CONV);
  assign pos_cap_first   = sample_track & ~chan_two_q;
  assign pos_cap_second  = sample_track & chan_two_q;
  assign neg_cap_connect = sample_track;
  assign power_up        = (st_q != acs_pkg::ACS_SHUT);
  assign dac_trial       = sar_q;

  // ----------------------------------------------------------------
  // serial output pin
  // ----------------------------------------------------------------
  logic dout_q;   // pin level
  logic oe_q;     // pin enable

  // lags the clock fall by the sync depth, about 30 ns, inside the host's window
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dout_q <= 1'b0;
      oe_q   <= 1'b0;
    end else if (cs_rise) begin
      dout_q <= 1'b0;
      oe_q   <= 1'b1;
    end else if (conv_done) begin
      dout_q <= sar_keep[`ACS_RES_BITS-1];
    end else if (st_q == acs_pkg::ACS_SHUT && valid_q) begin
      if (released_q || read_full) begin
        oe_q <= 1'b0;
      end else begin
        dout_q <= frame_bit(result_q, fall_since);
      end
    end
  end

  assign serial_data_out = dout_q;
  assign serial_data_oe  = oe_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  track_on_rise_a: assert property (cs_rise |=> sample_track && !sample_hold && power_up)
    else $error("no tracking after convert-start rise");
  hold_on_fall_a: assert property ((sample_track && cs_fall) |=> sample_hold && !sample_track)
    else $error("no hold after convert-start fall");
  msb_in_time_a: assert property ((sample_track && cs_fall) |-> ##[1:366] (conv_done || cs_rise))
    else $error("msb not ready in time");
  auto_shutdown_a: assert property (conv_done && !cs_rise |=> !power_up ##1 !power_up)
    else $error("no automatic shutdown");
  cap_routing_a: assert property (sample_track |-> (pos_cap_first ^ pos_cap_second) && neg_cap_connect)
    else $error("capacitor routing wrong during tracking");
  first_channel_a: assert property ((cs_rise && full_q) |=> pos_cap_first && !pos_cap_second)
    else $error("first channel not chosen");
  second_channel_a: assert property ((cs_rise && !full_q && !read_full) |=> pos_cap_second)
    else $error("second channel not chosen");
  dout_on_fall_a: assert property ((st_q == acs_pkg::ACS_SHUT && $past(st_q) == acs_pkg::ACS_SHUT
                                    && $changed(dout_q) && !$past(cs_rise))
                                   |-> $past(fall_since, 2) != $past(fall_since))
    else $error("output changed without a clock fall");
  msb_first_a: assert property ((conv_done && !cs_rise) |=> dout_q == result_q[`ACS_RES_BITS-1] && oe_q)
    else $error("msb not first");
  drive_low_a: assert property (cs_rise |=> oe_q && !dout_q ##1 oe_q)
    else $error("output not driven low on wake");
  frame_release_a: assert property ((st_q == acs_pkg::ACS_SHUT && read_full && !cs_rise) |=> !oe_q)
    else $error("output not released after frame");
  count_arms_a: assert property ($rose(full_q) |-> $past(read_full))
    else $error("readout flag set without twelve rises");

  first_conv_c: cover property (cs_rise && full_q ##[1:400] conv_done);
  second_conv_c: cover property (cs_rise && !full_q ##[1:400] conv_done);
  abort_conv_c: cover property (sample_hold && cs_rise);
  release_c: cover property ($fell(oe_q));

endmodule

// ===== verification/acs_host_model.sv
// host model: drives the convert-start pin and the serial clock, samples the data pin
`timescale 1ns/1ns
// ----------------------------------------------------------------
// host side of the converter
// ----------------------------------------------------------------
module acs_host_model (
  output logic      convert_start_pin, // convert-start pin towards the device
  output logic      link_sclk,         // serial clock, still outside frames
  input  wire logic serial_data_out    // device data pin, sampled on rises
);
  // pin low and clock still from time zero, as a real host idles
  initial begin
    convert_start_pin = 1'b0;
    link_sclk         = 1'b0;
  end

  // clock runs only around reset, so the link counters clear and leave reset; 15 ns period
  task automatic free_run(input int halves);
    for (int i = 0; i < halves; i++) begin
      if (i % 2 == 1) #8;
      else #7;
      link_sclk = ~link_sclk;
    end
  endtask

  // raise the pin; the high-low-high pattern asks for the second channel
  task automatic start(input bit second);
    convert_start_pin = 1'b1;
    if (second) begin
      #40 convert_start_pin = 1'b0;
      #40 convert_start_pin = 1'b1;
    end
  endtask

  // keep the pin high past the acquisition interval, then lower it
  task automatic hold_off();
    #1450 convert_start_pin = 1'b0;
  endtask

  // clock n bits; low phase 60 ns leaves room for the data to settle after each fall
  task automatic clock_bits(input int n, output logic [11:0] bits, output logic steady);
    logic seen;
    bits   = 12'h000;
    steady = 1'b1;
    for (int i = 0; i < n; i++) begin
      seen      = serial_data_out;
      bits      = {bits[10:0], seen};
      link_sclk = 1'b1;
      #45;
      // data must not move while the clock is high
      if (serial_data_out !== seen) steady = 1'b0;
      link_sclk = 1'b0;
      #60;
    end
  endtask
endmodule

// ===== verification/testbench.sv
// self-checking bench for the converter control block
`timescale 1ns/1ns
`include "acs_defs.svh"
module testbench;
  // ----------------------------------------------------------------
  // signals and counters
  // ----------------------------------------------------------------
  localparam logic [9:0]          CH1_CODE = 10'h3FF; // first channel level, full scale
  localparam logic [9:0]          CH2_CODE = 10'h15A; // second channel level
  logic                           ref_clk, rst, link_sclk, convert_start_pin, comparator_high;
  logic                           sample_track, sample_hold, pos_cap_first, pos_cap_second;
  logic                           neg_cap_connect, power_up, serial_data_out, serial_data_oe;
  logic [`ACS_RES_BITS-1:0]       dac_trial;     // trial code from the device
  logic [9:0]                     held_code;     // level seen by the sampler
  int                             n_mismatch, check_count, cycles;

  acs_ctrl i_dut (.ref_clk(ref_clk), .rst(rst), .link_sclk(link_sclk),
    .convert_start_pin(convert_start_pin), .comparator_high(comparator_high),
    .sample_track(sample_track), .sample_hold(sample_hold), .pos_cap_first(pos_cap_first),
    .pos_cap_second(pos_cap_second), .neg_cap_connect(neg_cap_connect), .power_up(power_up),
    .dac_trial(dac_trial), .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe));
  acs_host_model i_host (.convert_start_pin(convert_start_pin), .link_sclk(link_sclk),
    .serial_data_out(serial_data_out));

  // 100 MHz system clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // analog side: the sampler follows whichever channel its positive cap is on
  initial held_code = 10'h000;
  always @(posedge ref_clk) begin
    if (pos_cap_first) held_code <= CH1_CODE;
    else if (pos_cap_second) held_code <= CH2_CODE;
  end
  assign comparator_high = (held_code >= dac_trial);

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // hang guard: the whole run needs well under this many cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      $display("[FAIL] timeout expected 0 seen 1");
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // reset with the serial clock running, then the device must sit in shutdown
  task automatic do_reset();
    #1 rst = 1'b1;
    fork
      wait_cyc(8);
      i_host.free_run(12);
    join
    @(posedge ref_clk);
    #1 rst = 1'b0;
    // the link reset sync lets go only after two more link rises, so keep the clock going a little
    i_host.free_run(6);
    wait_cyc(2);
    chk("reset state", 12'h000, {power_up, sample_track, sample_hold, serial_data_oe, serial_data_out});
    // outside a conversion the trial code idles at the first trial value
    chk("reset trial", `ACS_SAR_FIRST, dac_trial);
  endtask

  // one conversion: track outputs, hold, timing of the msb and shutdown
  task automatic run_conversion(input bit second, input bit ch2, input logic [9:0] code);
    int n;
    i_host.start(second);
    wait_cyc(6);
    chk("track", 1'b1, sample_track);
    chk("caps", {!ch2, ch2, 1'b1}, {pos_cap_first, pos_cap_second, neg_cap_connect});
    chk("wake dout", 3'b110, {power_up, serial_data_oe, serial_data_out});
    i_host.hold_off();
    wait_cyc(6);
    chk("hold", 2'b10, {sample_hold, sample_track});
    chk("first trial", 12'h200, dac_trial);
    n = 6;
    while (sample_hold === 1'b1 && n < 400) begin
      wait_cyc(1);
      n++;
    end
    chk("conv within 370", 1'b1, n <= 370);
    chk("shutdown", 1'b0, power_up);
    chk("msb", {1'b1, code[9]}, {serial_data_oe, serial_data_out});
  endtask

  // read n bits and compare with the msb-first result and its zero tail
  task automatic read_frame(input int n, input logic [9:0] code);
    logic [11:0] bits;
    logic [11:0] exp;
    logic        steady;
    exp = {code, 2'b00} >> (12 - n);
    i_host.clock_bits(n, bits, steady);
    chk("serial bits", exp, bits);
    chk("steady while high", 1'b1, steady);
    wait_cyc(2);
    chk("pin release", n < 12, serial_data_oe);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst         = 1'b1;
    n_mismatch  = 0;
    check_count = 0;
    cycles      = 0;
    do_reset();
    run_conversion(1'b0, 1'b0, CH1_CODE);
    read_frame(12, CH1_CODE);
    run_conversion(1'b1, 1'b1, CH2_CODE);
    read_frame(5, CH2_CODE);
    run_conversion(1'b0, 1'b1, CH2_CODE);
    read_frame(12, CH2_CODE);
    run_conversion(1'b0, 1'b0, CH1_CODE);
    read_frame(3, CH1_CODE);
    do_reset();
    run_conversion(1'b0, 1'b0, CH1_CODE);
    read_frame(12, CH1_CODE);
    report_and_stop();
  end
endmodule
